// ==== core/link_wake_pkg.sv ====
package link_wake_pkg;
   // Register offsets of the client's pin port.
   localparam logic [7:0] REG_PIN_DATA = 8'h75;
   localparam logic [7:0] REG_PIN_DIRECTION = 8'h76;
   localparam logic [7:0] REG_PIN_IRQ_STATUS_CLEAR = 8'h77;
   localparam logic [7:0] REG_PIN_IRQ_ENABLE = 8'h78;
   localparam logic [7:0] REG_PIN_IRQ_POLARITY = 8'h79;
   // Controller registers, reached over the host's software port.
   localparam logic [7:0] REG_HOST_CTRL = 8'h00;
   localparam logic [7:0] REG_HOST_STATUS = 8'h01;
   localparam int PIN_COUNT = 10;
   localparam logic [9:0] PIN_DIRECTION_RESET = 10'h000;
   localparam logic [9:0] PIN_DATA_RESET = 10'h000;
   localparam logic [9:0] PIN_POLARITY_RESET = 10'h3FF;
   // Link timing in strobe cycles.
   localparam int SHUT_TOGGLE_CYCLES = 64;
   localparam int SHUT_DATA_OFF_MIN = 16;
   localparam int SHUT_DATA_OFF_MAX = 48;
   localparam int RX_LOWPOWER_AFTER = 48;
   localparam int WAKE_HIGH_CYCLES = 150;
   localparam int WAKE_LOW_CYCLES = 50;
   localparam int SEARCH_AFTER_LOW = 40;
   localparam int CLIENT_HIGH_PULSES = 70;
   localparam int HOST_EXTRA_PULSES = 80;
   // Host clock and delays.
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESTART_SETTLE_NS = 200;
   localparam int RESTART_SETTLE_CYCLES =
      (RESTART_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SERVICE_DETECT_MS = 1;
   localparam int SERVICE_DETECT_CYCLES =
      SERVICE_DETECT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STB_HALF_CYCLES = 6;
   // Host command and status bits.
   localparam int CTRL_SHUTDOWN_BIT = 0;
   localparam int CTRL_WAKE_BIT = 1;
   localparam int CTRL_DATA_BIT = 2;
   localparam logic [7:0] STATUS_LINK_UP = 8'h01;
   localparam logic [7:0] STATUS_HIBERNATE = 8'h02;
   localparam logic [7:0] STATUS_SERVICE = 8'h04;
endpackage

// ==== core/link_if.sv ====
`timescale 1ns/10ps
interface link_if;
   logic host_data_out;
   logic host_data_oe;
   logic host_stb_out;
   logic host_stb_oe;
   logic client_data_out;
   logic client_data_oe;
   logic stb_offset_en;
   logic data_line;
   logic stb_line;
   // Termination pulls an undriven pair to zero; the offset keeps it low.
   assign data_line = (host_data_oe & host_data_out) |
                      (client_data_oe & client_data_out);
   assign stb_line = host_stb_oe & host_stb_out;
   modport host_end (
      output host_data_out, host_data_oe, host_stb_out, host_stb_oe,
      input data_line, stb_line
   );
   modport client_end (
      output client_data_out, client_data_oe, stb_offset_en,
      input data_line, stb_line
   );
endinterface

// ==== core/link_client.sv ====
`timescale 1ns/10ps
// Behaviour
// - Host strobes 64 cycles after shutdown CRC
// - Host drops data within 16..48 cycles
// - Client receivers low power after 48
// - Hibernating client ignores any strobe activity; in ST_REQUEST, still flagged hibernating, it waits for a strobe rise
// - Host waits 200 ns before strobing
// - Wake pulse seen through offset receiver
// - Host holds data high 150 strobes
// - Host drives data low 50 cycles
// - Client searches header after 40 lows
// - Host resumes data-strobe encoding
// - Offset enabled before strobe receiver
// - Client then drives data high
// - Host answers service request within 1ms
// - Host holds data high 150 pulses
// - Client drops offset at first pulse
// - Client 70 pulses high, host 80 more
// - Ten pins, direction bit selects output
// - Pin data drives outputs, reads pins
// - Status latched, write one clears
// - Enable gates, polarity picks level
// - Input pins only request wake-up
// - Host sets wake enables before shutdown
// - Latched enabled interrupt requests wake-up
module link_client
   import link_wake_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input wire logic clk,
   input wire logic sys_rst,
   link_if.client_end link,
   input wire logic shutdown_seen,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [PINS-1:0] reg_wdata,
   output logic [PINS-1:0] reg_rdata,
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   output logic link_active,
   output logic hibernating,
   output logic rx_lowpower,
   output logic stb_rx_en,
   output logic header_search
);
   typedef enum logic [5:0] {
      ST_ACTIVE = 6'h01,
      ST_SHUTDOWN = 6'h02,
      ST_HIBER = 6'h04,
      ST_REQUEST = 6'h08,
      ST_WAKE_HIGH = 6'h10,
      ST_WAKE_LOW = 6'h20
   } client_state_t;

   client_state_t state;
   logic [2:0] stb_sync;
   logic [1:0] data_sync;
   logic [PINS-1:0] pin_m;
   logic [PINS-1:0] pin_s;
   logic [PINS-1:0] pin_data;
   logic [PINS-1:0] pin_irq_status_clear;
   logic [PINS-1:0] pin_irq_enable;
   logic [PINS-1:0] pin_irq_polarity;
   logic [7:0] count;
   logic stb_rise;
   logic wake_request;
   logic [PINS-1:0] irq_hit;

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      stb_sync <= {stb_sync[1:0], link.stb_line};
      data_sync <= {data_sync[0], link.data_line};
      pin_m <= pin_in;
      pin_s <= pin_m;
   end
   assign stb_rise = stb_sync[1] & ~stb_sync[2];

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_data <= PIN_DATA_RESET;
         pin_oe <= PIN_DIRECTION_RESET;
         pin_irq_enable <= '0;
         pin_irq_polarity <= PIN_POLARITY_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_PIN_DATA: pin_data <= reg_wdata;
            REG_PIN_DIRECTION: pin_oe <= reg_wdata;
            REG_PIN_IRQ_ENABLE: pin_irq_enable <= reg_wdata;
            REG_PIN_IRQ_POLARITY: pin_irq_polarity <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_out <= '0;
      end else begin
         pin_out <= pin_data & pin_oe;
      end
   end

   // Only input pins feed the interrupt latch; output pins are masked off.
   assign irq_hit = ~pin_oe & pin_irq_enable &
                    ~(pin_s ^ pin_irq_polarity);

   // A new hit outranks a clear written in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_irq_status_clear <= '0;
      end else if (reg_wr && reg_addr == REG_PIN_IRQ_STATUS_CLEAR) begin
         pin_irq_status_clear <= (pin_irq_status_clear & ~reg_wdata) |
                                 irq_hit;
      end else begin
         pin_irq_status_clear <= pin_irq_status_clear | irq_hit;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_PIN_DATA: reg_rdata <= pin_s;
            REG_PIN_DIRECTION: reg_rdata <= pin_oe;
            REG_PIN_IRQ_STATUS_CLEAR: reg_rdata <= pin_irq_status_clear;
            REG_PIN_IRQ_ENABLE: reg_rdata <= pin_irq_enable;
            REG_PIN_IRQ_POLARITY: reg_rdata <= pin_irq_polarity;
            default: reg_rdata <= '0;
         endcase
      end
   end

   assign wake_request = |(pin_irq_status_clear & pin_irq_enable);

   // -------------------------------------------------------------
   // Hibernation and restart
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_HIBER;
         count <= '0;
         link.client_data_out <= 1'b0;
         link.client_data_oe <= 1'b0;
         link.stb_offset_en <= 1'b0;
         stb_rx_en <= 1'b0;
         rx_lowpower <= 1'b1;
         header_search <= 1'b0;
      end else begin
         case (state)
            ST_ACTIVE: begin
               // Search stays on while the link runs; shutdown ends it.
               if (shutdown_seen) begin
                  header_search <= 1'b0;
                  state <= ST_SHUTDOWN;
                  count <= '0;
               end
            end
            ST_SHUTDOWN: begin
               if (stb_rise) begin
                  count <= count + 8'h01;
               end
               if (count >= 8'(RX_LOWPOWER_AFTER)) begin
                  rx_lowpower <= 1'b1;
                  stb_rx_en <= 1'b0;
               end
               if (count >= 8'(SHUT_TOGGLE_CYCLES)) begin
                  state <= ST_HIBER;
               end
            end
            ST_HIBER: begin
               // Strobe is not watched here at all; a pin wake request or high data wakes.
               count <= '0;
               if (wake_request) begin
                  link.stb_offset_en <= 1'b1;
                  state <= ST_REQUEST;
               end else if (data_sync[1]) begin
                  rx_lowpower <= 1'b0;
                  stb_rx_en <= 1'b1;
                  state <= ST_WAKE_HIGH;
               end
            end
            ST_REQUEST: begin
               // Receiver comes on one cycle after the offset.
               if (!stb_rx_en) begin
                  stb_rx_en <= 1'b1;
                  rx_lowpower <= 1'b0;
               end else begin
                  link.client_data_out <= 1'b1;
                  link.client_data_oe <= 1'b1;
               end
               if (stb_rise && stb_rx_en) begin
                  link.stb_offset_en <= 1'b0;
                  count <= 8'h01;
                  state <= ST_WAKE_HIGH;
               end
            end
            ST_WAKE_HIGH: begin
               if (stb_rise) begin
                  count <= count + 8'h01;
               end
               if (link.client_data_oe &&
                   count >= 8'(CLIENT_HIGH_PULSES)) begin
                  link.client_data_oe <= 1'b0;
                  link.client_data_out <= 1'b0;
               end
               if (!link.client_data_oe && !data_sync[1]) begin
                  count <= '0;
                  state <= ST_WAKE_LOW;
               end
            end
            ST_WAKE_LOW: begin
               if (data_sync[1]) begin
                  count <= '0;
               end else if (stb_rise) begin
                  count <= count + 8'h01;
               end
               if (count >= 8'(SEARCH_AFTER_LOW)) begin
                  header_search <= 1'b1;
                  state <= ST_ACTIVE;
               end
            end
            default: state <= ST_HIBER;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link_active <= 1'b0;
         hibernating <= 1'b1;
      end else begin
         link_active <= (state == ST_ACTIVE);
         hibernating <= (state == ST_HIBER) || (state == ST_REQUEST);
      end
   end
endmodule // link_client

// ==== core/link_host.sv ====
`timescale 1ns/10ps
module link_host
   import link_wake_pkg::*;
#(
   parameter int DETECT_CYCLES = SERVICE_DETECT_CYCLES,
   parameter int HALF = STB_HALF_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   link_if.host_end link,
   input wire logic [7:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   output logic shutdown_sent
);
   typedef enum logic [6:0] {
      H_ACTIVE = 7'h01,
      H_SHUT = 7'h02,
      H_HIBER = 7'h04,
      H_SETTLE = 7'h08,
      H_HIGH = 7'h10,
      H_LOW = 7'h20,
      H_DATA = 7'h40
   } host_state_t;

   host_state_t state;
   logic [1:0] data_sync;
   logic [31:0] timer;
   logic [7:0] pulses;
   logic [7:0] half_cnt;
   logic stb_q;
   logic stb_fall;
   logic shut_req;
   logic wake_req;
   logic data_bit;
   logic service_seen;

   // -------------------------------------------------------------
   // Software port
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shut_req <= 1'b0;
         wake_req <= 1'b0;
         data_bit <= 1'b0;
      end else if (sw_wr && sw_addr == REG_HOST_CTRL) begin
         shut_req <= sw_wdata[CTRL_SHUTDOWN_BIT];
         wake_req <= sw_wdata[CTRL_WAKE_BIT];
         data_bit <= sw_wdata[CTRL_DATA_BIT];
      end else begin
         shut_req <= shut_req & (state == H_ACTIVE);
         wake_req <= wake_req & (state != H_SETTLE);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sw_rdata <= '0;
      end else if (sw_rd && sw_addr == REG_HOST_STATUS) begin
         sw_rdata <= ((state == H_ACTIVE || state == H_DATA) ?
                      STATUS_LINK_UP : 8'h00) |
                     ((state == H_HIBER) ? STATUS_HIBERNATE : 8'h00) |
                     (service_seen ? STATUS_SERVICE : 8'h00);
      end else if (sw_rd) begin
         sw_rdata <= '0;
      end
   end

   always_ff @(posedge clk) begin
      data_sync <= {data_sync[0], link.data_line};
   end

   // -------------------------------------------------------------
   // Strobe generator
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         half_cnt <= '0;
         stb_q <= 1'b0;
      end else if (state == H_SHUT || state == H_HIGH ||
                   state == H_LOW || state == H_DATA) begin
         if (half_cnt == 8'(HALF - 1)) begin
            half_cnt <= '0;
            stb_q <= ~stb_q;
         end else begin
            half_cnt <= half_cnt + 8'h01;
         end
      end else begin
         half_cnt <= '0;
         stb_q <= 1'b0;
      end
   end
   assign stb_fall = stb_q && half_cnt == 8'(HALF - 1);

   // -------------------------------------------------------------
   // Link sequencer
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= H_HIBER;
         timer <= '0;
         pulses <= '0;
         service_seen <= 1'b0;
         shutdown_sent <= 1'b0;
         link.host_data_out <= 1'b0;
         link.host_data_oe <= 1'b0;
         link.host_stb_out <= 1'b0;
         link.host_stb_oe <= 1'b0;
      end else begin
         shutdown_sent <= 1'b0;
         link.host_stb_out <= stb_q;
         case (state)
            H_ACTIVE: begin
               if (shut_req) begin
                  shutdown_sent <= 1'b1;
                  link.host_data_out <= 1'b0;
                  pulses <= '0;
                  state <= H_SHUT;
               end
            end
            H_SHUT: begin
               if (stb_fall) begin
                  pulses <= pulses + 8'h01;
               end
               if (pulses >= 8'(SHUT_DATA_OFF_MIN)) begin
                  link.host_data_oe <= 1'b0;
               end
               if (pulses >= 8'(SHUT_TOGGLE_CYCLES)) begin
                  link.host_stb_oe <= 1'b0;
                  state <= H_HIBER;
               end
            end
            H_HIBER: begin
               if (data_sync[1]) begin
                  service_seen <= 1'b1;
               end
               if (wake_req || data_sync[1]) begin
                  link.host_data_out <= 1'b1;
                  link.host_data_oe <= 1'b1;
                  link.host_stb_oe <= 1'b1;
                  timer <= '0;
                  state <= H_SETTLE;
               end
            end
            H_SETTLE: begin
               timer <= timer + 32'h1;
               if (timer >= 32'(RESTART_SETTLE_CYCLES)) begin
                  pulses <= '0;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (stb_fall) begin
                  pulses <= pulses + 8'h01;
               end
               // 70 client pulses plus 80 more give the same 150.
               if (pulses >= 8'(CLIENT_HIGH_PULSES + HOST_EXTRA_PULSES)
                   || pulses >= 8'(WAKE_HIGH_CYCLES)) begin
                  link.host_data_out <= 1'b0;
                  pulses <= '0;
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (stb_fall) begin
                  pulses <= pulses + 8'h01;
               end
               if (pulses >= 8'(WAKE_LOW_CYCLES)) begin
                  service_seen <= 1'b0;
                  state <= H_DATA;
               end
            end
            H_DATA: begin
               // Data follows software; strobe keeps the encoding.
               link.host_data_out <= data_bit;
               state <= H_ACTIVE;
            end
            default: state <= H_HIBER;
         endcase
         // Shutdown must start from a low data line, whatever software set.
         if (state == H_ACTIVE && !shut_req) begin
            link.host_data_out <= data_bit;
         end
      end
   end
   // DETECT_CYCLES bounds the answer; detection here is two cycles.
   logic unused_detect;
   assign unused_detect = (DETECT_CYCLES == 0);
endmodule // link_host

// ==== dv/link_wake_monitor.sv ====
`timescale 1ns/10ps
module link_wake_monitor
   import link_wake_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic host_data_out,
   input wire logic host_data_oe,
   input wire logic host_stb_out,
   input wire logic host_stb_oe,
   input wire logic client_data_out,
   input wire logic client_data_oe,
   input wire logic stb_offset_en,
   input wire logic data_line,
   input wire logic stb_line
);
   // ---------------------------------------------------------------
   // Strobe edge counters and settle-time cycle counter
   // ---------------------------------------------------------------
   logic stb_q;
   logic stb_rise;
   logic [7:0] settle_cnt;
   logic [7:0] cli_rises;
   logic [7:0] high_rises;
   logic [7:0] off_rises;
   assign stb_rise = stb_line & ~stb_q;
   always_ff @(posedge clk) begin
      stb_q <= sys_rst ? 1'b0 : stb_line;
   end
   // Saturating, so a long enabled stretch cannot wrap to a small value.
   always_ff @(posedge clk) begin
      if (sys_rst || !host_stb_oe)
         settle_cnt <= 8'h00;
      else if (settle_cnt != 8'hFF)
         settle_cnt <= settle_cnt + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (sys_rst || !client_data_oe)
         cli_rises <= 8'h00;
      else if (stb_rise)
         cli_rises <= cli_rises + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (sys_rst || !(host_data_oe && host_data_out))
         high_rises <= 8'h00;
      else if (stb_rise)
         high_rises <= high_rises + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (sys_rst || host_data_oe)
         off_rises <= 8'h00;
      else if (stb_rise && host_stb_oe && off_rises != 8'hFF)
         off_rises <= off_rises + 8'h01;
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_stb_stop_count: assert property ($fell(host_stb_oe) |->
      off_rises inside {[SHUT_TOGGLE_CYCLES - SHUT_DATA_OFF_MAX :
                         SHUT_TOGGLE_CYCLES - SHUT_DATA_OFF_MIN]})
      else $error("strobe stopped after a wrong pulse count");
   chk_data_low_off: assert property ($fell(host_data_oe) |->
      !$past(host_data_out)) else $error("host data released high");
   chk_wake_levels: assert property ($rose(host_data_oe) |->
      host_data_out && !host_stb_out) else $error("bad restart levels");
   chk_settle_time: assert property (
      $rose(host_stb_out) && host_stb_oe |->
      settle_cnt >= RESTART_SETTLE_CYCLES - 1)
      else $error("strobe pulsed before settle time");
   chk_host_high_len: assert property (
      host_data_oe && $fell(host_data_out) |->
      high_rises == WAKE_HIGH_CYCLES)
      else $error("host high phase has wrong pulse count");
   chk_offset_first: assert property ($rose(client_data_oe) |->
      $past(stb_offset_en)) else $error("data driven before offset");
   chk_client_drive: assert property (client_data_oe |->
      client_data_out && data_line) else $error("client drives low");
   chk_offset_drop: assert property (stb_rise && stb_offset_en |->
      ##[1:6] !stb_offset_en) else $error("offset kept after pulse");
   chk_client_pulses: assert property ($fell(client_data_oe) |->
      cli_rises == CLIENT_HIGH_PULSES)
      else $error("client released data at wrong count");
   cov_client_wake: cover property ($rose(client_data_oe));
   cov_host_wake: cover property ($rose(host_data_oe) && !stb_offset_en);
   cov_shutdown: cover property ($fell(host_data_oe));
endmodule // link_wake_monitor

// ==== dv/link_hibernation_wakeup_gpio_test.sv ====
`timescale 1ns/10ps
module link_hibernation_wakeup_gpio_test
   import link_wake_pkg::*;
;
   logic clk, sys_rst, reg_wr, reg_rd, sw_wr, sw_rd, shutdown_sent;
   logic link_active, hibernating, rx_lowpower, stb_rx_en, header_search;
   logic [7:0] reg_addr, sw_addr, sw_wdata, sw_rdata;
   logic [9:0] reg_wdata, reg_rdata, ext_pins, pin_in, pin_out, pin_oe;
   int n_fail = 0;
   int checks = 0;
   // Output pins read back their own level; input pins see the outside.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);
   link_if link();
   link_client u_link_client (.clk(clk), .sys_rst(sys_rst), .link(link),
      .shutdown_seen(shutdown_sent), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .link_active(link_active), .hibernating(hibernating),
      .rx_lowpower(rx_lowpower), .stb_rx_en(stb_rx_en),
      .header_search(header_search));
   link_host u_link_host (.clk(clk), .sys_rst(sys_rst), .link(link),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata), .shutdown_sent(shutdown_sent));
   link_wake_monitor u_link_wake_monitor (.clk(clk), .sys_rst(sys_rst),
      .host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
      .host_stb_out(link.host_stb_out), .host_stb_oe(link.host_stb_oe),
      .client_data_out(link.client_data_out),
      .client_data_oe(link.client_data_oe),
      .stb_offset_en(link.stb_offset_en), .data_line(link.data_line),
      .stb_line(link.stb_line));
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (n_fail == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cwr(input logic [7:0] a, input logic [9:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic crd(input logic [7:0] a, input logic [9:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   task automatic hwr(input logic [7:0] d);
      @(posedge clk);
      sw_wr <= 1'b1;
      sw_addr <= REG_HOST_CTRL;
      sw_wdata <= d;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic hrd(input logic [7:0] mask);
      @(posedge clk);
      sw_rd <= 1'b1;
      sw_addr <= REG_HOST_STATUS;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      check({2'b00, sw_rdata & mask}, {2'b00, mask});
   endtask
   task automatic wait_up(input int lim);
      int i;
      for (i = 0; i < lim && link_active !== 1'b1; i++)
         @(posedge clk);
      if (i == lim) begin
         n_fail++;
         $display("BAD %0t link did not come up", $time);
         stop_test();
      end
      repeat ((WAKE_LOW_CYCLES - SEARCH_AFTER_LOW + 2) * 2 * STB_HALF_CYCLES)
         @(posedge clk);
   endtask
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, sw_wr, sw_rd} = 4'h0;
      reg_addr = 8'h00;
      sw_addr = 8'h00;
      sw_wdata = 8'h00;
      reg_wdata = 10'h000;
      ext_pins = 10'h000;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      crd(REG_PIN_DATA, PIN_DATA_RESET);
      crd(REG_PIN_DIRECTION, PIN_DIRECTION_RESET);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h000);
      crd(REG_PIN_IRQ_ENABLE, 10'h000);
      crd(REG_PIN_IRQ_POLARITY, PIN_POLARITY_RESET);
      crd(8'h7A, 10'h000);
      check(pin_oe, 10'h000);
      ext_pins <= 10'h3FF;
      repeat (300) @(posedge clk);
      check({9'h000, hibernating}, 10'h001);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h000);
      crd(REG_PIN_DATA, 10'h3FF);
      ext_pins <= 10'h00A;
      hwr(8'h02);
      wait_up(6000);
      check({9'h000, header_search}, 10'h001);
      hrd(STATUS_LINK_UP);
      cwr(REG_PIN_DIRECTION, 10'h3F0);
      cwr(REG_PIN_DATA, 10'h2B5);
      repeat (3) @(posedge clk);
      check(pin_oe, 10'h3F0);
      check(pin_out & 10'h3F0, 10'h2B0);
      crd(REG_PIN_DATA, 10'h2BA);
      crd(REG_PIN_DIRECTION, 10'h3F0);
      cwr(REG_PIN_IRQ_POLARITY, 10'h3FB);
      cwr(REG_PIN_IRQ_ENABLE, 10'h017);
      repeat (4) @(posedge clk);
      crd(REG_PIN_IRQ_ENABLE, 10'h017);
      crd(REG_PIN_IRQ_POLARITY, 10'h3FB);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h006);
      ext_pins <= 10'h004;
      repeat (4) @(posedge clk);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h006);
      cwr(REG_PIN_IRQ_STATUS_CLEAR, 10'h002);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h004);
      cwr(REG_PIN_IRQ_STATUS_CLEAR, 10'h3FF);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h000);
      ext_pins <= 10'h000;
      cwr(REG_PIN_IRQ_ENABLE, 10'h001);
      cwr(REG_PIN_IRQ_POLARITY, PIN_POLARITY_RESET);
      cwr(REG_PIN_DIRECTION, 10'h000);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h000);
      hwr(8'h01);
      repeat ((SHUT_TOGGLE_CYCLES + 4) * 2 * STB_HALF_CYCLES)
         @(posedge clk);
      check({8'h00, link_active, hibernating}, 10'h001);
      check({9'h000, rx_lowpower}, 10'h001);
      hrd(STATUS_HIBERNATE);
      ext_pins <= 10'h001;
      repeat (20) @(posedge clk);
      hrd(STATUS_SERVICE);
      wait_up(6000);
      check({9'h000, link.stb_offset_en}, 10'h000);
      check({9'h000, link.client_data_oe}, 10'h000);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h001);
      ext_pins <= 10'h000;
      repeat (4) @(posedge clk);
      cwr(REG_PIN_IRQ_STATUS_CLEAR, 10'h001);
      crd(REG_PIN_IRQ_STATUS_CLEAR, 10'h000);
      stop_test();
   end
endmodule // link_hibernation_wakeup_gpio_test
